/* include/lcr_pkg.sv */
// Constants, types and register map of the lighting control register bank
package lcr_pkg;

   // Register indices inside the bank
   localparam int unsigned LCR_NREG    = 6;
   localparam int unsigned LCR_IX_RATE = 0;
   localparam int unsigned LCR_IX_FL   = 1;
   localparam int unsigned LCR_IX_SEQ  = 2;
   localparam int unsigned LCR_IX_RGB1 = 3;
   localparam int unsigned LCR_IX_RGB2 = 4;
   localparam int unsigned LCR_IX_AUD  = 5;

   // Register byte addresses
   localparam logic [7:0] LCR_SWITCHER_RATE_CTRL_ADDR     = 8'h0E;
   localparam logic [7:0] LCR_FLASH_DRIVER_CTRL_ADDR      = 8'h10;
   localparam logic [7:0] LCR_PATTERN_SEQUENCER_CTRL_ADDR = 8'h11;
   localparam logic [7:0] LCR_RGB_GROUP1_LIMITS_ADDR      = 8'h12;
   localparam logic [7:0] LCR_RGB_GROUP2_LIMITS_ADDR      = 8'h13;
   localparam logic [7:0] LCR_AUDIO_FOLLOW_CTRL1_ADDR     = 8'h2A;

   localparam logic [LCR_NREG-1:0][7:0] LCR_ADDR = {
      LCR_AUDIO_FOLLOW_CTRL1_ADDR, LCR_RGB_GROUP2_LIMITS_ADDR,
      LCR_RGB_GROUP1_LIMITS_ADDR, LCR_PATTERN_SEQUENCER_CTRL_ADDR,
      LCR_FLASH_DRIVER_CTRL_ADDR, LCR_SWITCHER_RATE_CTRL_ADDR};

   // Writable bits; the rest read as zero
   localparam logic [LCR_NREG-1:0][7:0] LCR_WMASK = {
      8'hFF, 8'hFF, 8'h3F, 8'h07, 8'h3F, 8'h07};

   // Reset values
   localparam logic [LCR_NREG-1:0][7:0] LCR_RESET = {
      8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};

   // Switching rate field
   localparam int unsigned LCR_RATE_TOP_BIT = 2;
   localparam int unsigned LCR_RATE_MID_BIT = 1;
   localparam logic [1:0]  LCR_RATE_1M00    = 2'h0;
   localparam logic [1:0]  LCR_RATE_1M67    = 2'h1;
   localparam logic [1:0]  LCR_RATE_2M00    = 2'h2;

   // Flash driver control fields
   localparam int unsigned LCR_FL_DIM_BIT = 5;
   localparam int unsigned LCR_FL_LEN_LSB = 3;
   localparam int unsigned LCR_FL_LVL_LSB = 1;
   localparam int unsigned LCR_FL_EN_BIT  = 0;
   localparam logic [1:0]  LCR_FL_LEN_PIN = 2'h3;

   // Pattern sequencer control fields
   localparam int unsigned LCR_SEQ_RUN_BIT   = 2;
   localparam int unsigned LCR_SEQ_LOOP_BIT  = 1;
   localparam int unsigned LCR_SEQ_CURVE_BIT = 0;

   // RGB limit fields
   localparam int unsigned LCR_RED_LSB = 4;
   localparam int unsigned LCR_GRN_LSB = 2;
   localparam int unsigned LCR_BLU_LSB = 0;

   // Audio follow control fields
   localparam int unsigned LCR_AUD_GAIN_LSB   = 5;
   localparam int unsigned LCR_AUD_MODE_BIT   = 4;
   localparam int unsigned LCR_AUD_AGC_BIT    = 3;
   localparam int unsigned LCR_AUD_FOLLOW_BIT = 2;
   localparam int unsigned LCR_AUD_SRC_LSB    = 0;
   localparam logic [4:0]  LCR_GAIN_STEP_DB   = 5'h03;

   // Flash timing
   localparam int unsigned LCR_CLK_HZ       = 25_000_000;
   localparam int unsigned LCR_FL_STEP_MS   = 200;
   localparam int unsigned LCR_FL_STEP_CYC  = (LCR_CLK_HZ / 1000) * LCR_FL_STEP_MS;
   localparam int unsigned LCR_FL_CNT_W     = 32;

   // Sequencer control states
   typedef enum logic [2:0] {
      LCR_SEQ_IDLE = 3'b001,
      LCR_SEQ_RUN  = 3'b010,
      LCR_SEQ_DONE = 3'b100
   } lcr_seq_e;

   typedef struct packed {
      logic [1:0] red;
      logic [1:0] green;
      logic [1:0] blue;
   } lcr_rgb_limits_s;

   typedef struct packed {
      logic       on;
      logic       dimming;
      logic [1:0] level;
   } lcr_flash_s;

   typedef struct packed {
      logic       run;
      logic       restart;
      logic       loop;
      logic       curve;
   } lcr_seq_s;

   typedef struct packed {
      logic [2:0] gain_code;
      logic [4:0] gain_db;
      logic       freq_mode;
      logic       auto_level;
      logic       follow;
      logic [1:0] source;
   } lcr_audio_s;

endpackage : lcr_pkg

/* hdl/lcr_flash_timer.sv */
// Flash duration timer counting whole flash steps
`timescale 1ns/100ps
module lcr_flash_timer #(
   parameter int unsigned STEP_CYC = lcr_pkg::LCR_FL_STEP_CYC,
   parameter int unsigned CNT_W    = lcr_pkg::LCR_FL_CNT_W
) (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       start_i,
   input  wire logic       abort_i,
   input  wire logic [1:0] len_code_i,
   // Status
   output logic            busy_o
);
   import lcr_pkg::*;

   typedef struct packed {
      logic             busy;
      logic [CNT_W-1:0] cnt;
      logic [1:0]       steps;
   } lcr_tmr_s;

   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);

   lcr_tmr_s st_r;
   lcr_tmr_s st_nxt;

   // Flash lasts (code + 1) steps of 200 ms
   always_comb begin
      st_nxt = st_r;
      if (abort_i) begin
         st_nxt.busy = 1'b0;
      end else if (start_i) begin
         st_nxt.busy  = 1'b1;
         st_nxt.cnt   = STEP_LAST;
         st_nxt.steps = len_code_i; // see RULE3
      end else if (st_r.busy) begin
         if (st_r.cnt == '0) begin
            if (st_r.steps == 2'h0) begin
               st_nxt.busy = 1'b0;
            end else begin
               st_nxt.steps = st_r.steps - 2'h1;
               st_nxt.cnt   = STEP_LAST;
            end
         end else begin
            st_nxt.cnt = st_r.cnt - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o = st_r.busy;

endmodule : lcr_flash_timer

/* hdl/lcr_regs.sv */
// Lighting control register bank with flash timing and sequencer start control
`timescale 1ns/100ps

// Summary of operation
// RULE1: rate field picks 2.00, 1.67, 1.00 MHz
// RULE2: dimming bit applies PWM to flash driver
// RULE3: length code times 200/400/600 ms or pin
// RULE4: level code sets quarter to full flash current
// RULE5: enable bit switches flash driver on, resets off
// RULE6: run bit starts sequencer at command one
// RULE7: loop bit repeats pattern, else once only
// RULE8: curve bit selects intensity mode for all colours
// RULE9: group one colour limits quarter to full
// RULE10: group two colour limits quarter to full
// RULE11: gain field zero to 21 dB, 3 dB steps
// RULE12: filter bit selects amplitude or frequency mode
// RULE13: auto level bit enables automatic gain control
// RULE14: source field picks audio, temperature, light, none
// RULE15: follow bit enables audio synchronisation of LEDs
module lcr_regs #(
   parameter int unsigned FL_STEP_CYC = lcr_pkg::LCR_FL_STEP_CYC
) (
   // Clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     rst_i,
   // Register port
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic [7:0]               reg_wdata_i,
   output logic      [7:0]               reg_rdata_o,
   // Boost converter
   output logic      [1:0]               boost_rate_o,
   // Flash driver
   input  wire logic                     flash_trigger_i,
   output lcr_pkg::lcr_flash_s           flash_o,
   // Pattern sequencer
   input  wire logic                     seq_pattern_end_i,
   output lcr_pkg::lcr_seq_s             seq_o,
   // RGB drivers
   output lcr_pkg::lcr_rgb_limits_s      rgb1_limits_o,
   output lcr_pkg::lcr_rgb_limits_s      rgb2_limits_o,
   // Audio follow and converter input
   output lcr_pkg::lcr_audio_s           audio_o
);
   import lcr_pkg::*;

   typedef struct packed {
      logic [LCR_NREG-1:0][7:0] regs;
      logic [7:0]               rdata;
      logic [1:0]               rate;
      logic                     trig_prev;
      lcr_flash_s               flash;
      lcr_seq_e                 seq_state;
      logic                     restart;
      lcr_rgb_limits_s          rgb1;
      lcr_rgb_limits_s          rgb2;
      lcr_audio_s               audio;
   } lcr_state_s;

   lcr_state_s st_r;
   lcr_state_s st_nxt;

   logic       tmr_busy;
   logic       tmr_start;
   logic       tmr_abort;
   logic [7:0] fl_reg;
   logic [7:0] seq_reg;
   logic [7:0] aud_reg;
   logic [1:0] fl_len;
   logic       fl_en;

   assign fl_reg  = st_r.regs[LCR_IX_FL];
   assign seq_reg = st_r.regs[LCR_IX_SEQ];
   assign aud_reg = st_r.regs[LCR_IX_AUD];
   assign fl_len  = fl_reg[LCR_FL_LEN_LSB +: 2];
   assign fl_en   = fl_reg[LCR_FL_EN_BIT];

   // Timed flash starts on a rising trigger while the driver is enabled
   assign tmr_start = fl_en && (fl_len != LCR_FL_LEN_PIN) && flash_trigger_i
                      && !st_r.trig_prev; // see RULE3
   // Disabling the driver or moving to pin mode cuts a running flash short
   assign tmr_abort = !fl_en || (fl_len == LCR_FL_LEN_PIN); // see RULE5

   lcr_flash_timer #(
      .STEP_CYC (FL_STEP_CYC),
      .CNT_W    (LCR_FL_CNT_W)
   ) u_flash_timer (
      .mclk_i     (mclk_i),
      .rst_i      (rst_i),
      .start_i    (tmr_start),
      .abort_i    (tmr_abort),
      .len_code_i (fl_len),
      .busy_o     (tmr_busy)
   );

   function automatic lcr_rgb_limits_s lcr_split_limits(input logic [7:0] val);
      lcr_rgb_limits_s lim;
      lim.red   = val[LCR_RED_LSB +: 2];
      lim.green = val[LCR_GRN_LSB +: 2];
      lim.blue  = val[LCR_BLU_LSB +: 2];
      return lim;
   endfunction : lcr_split_limits

   always_comb begin
      st_nxt         = st_r;
      st_nxt.restart = 1'b0;

      // Register writes and reads, one decode per register
      for (int i = 0; i < LCR_NREG; i++) begin
         if (reg_wr_i && (reg_addr_i == LCR_ADDR[i])) begin
            st_nxt.regs[i] = reg_wdata_i & LCR_WMASK[i];
         end
      end
      if (reg_rd_i) begin
         st_nxt.rdata = 8'h00;
         for (int i = 0; i < LCR_NREG; i++) begin
            if (reg_addr_i == LCR_ADDR[i]) begin
               st_nxt.rdata = st_r.regs[i];
            end
         end
      end

      // Switching rate, top bit wins over the middle bit
      if (st_r.regs[LCR_IX_RATE][LCR_RATE_TOP_BIT]) begin
         st_nxt.rate = LCR_RATE_2M00; // see RULE1
      end else if (st_r.regs[LCR_IX_RATE][LCR_RATE_MID_BIT]) begin
         st_nxt.rate = LCR_RATE_1M67; // see RULE1
      end else begin
         st_nxt.rate = LCR_RATE_1M00; // see RULE1
      end

      // Flash driver
      st_nxt.trig_prev     = flash_trigger_i;
      st_nxt.flash.dimming = fl_reg[LCR_FL_DIM_BIT]; // see RULE2
      st_nxt.flash.level   = fl_reg[LCR_FL_LVL_LSB +: 2]; // see RULE4
      if (!fl_en) begin
         st_nxt.flash.on = 1'b0; // see RULE5
      end else if (fl_len == LCR_FL_LEN_PIN) begin
         st_nxt.flash.on = flash_trigger_i; // see RULE3
      end else begin
         st_nxt.flash.on = tmr_busy; // see RULE3
      end

      // Sequencer start and loop control
      case (st_r.seq_state)
         LCR_SEQ_IDLE: begin
            if (seq_reg[LCR_SEQ_RUN_BIT]) begin
               st_nxt.seq_state = LCR_SEQ_RUN; // see RULE6
               st_nxt.restart   = 1'b1; // see RULE6
            end
         end
         LCR_SEQ_RUN: begin
            if (!seq_reg[LCR_SEQ_RUN_BIT]) begin
               st_nxt.seq_state = LCR_SEQ_IDLE; // see RULE6
            end else if (seq_pattern_end_i) begin
               if (seq_reg[LCR_SEQ_LOOP_BIT]) begin
                  st_nxt.restart = 1'b1; // see RULE7
               end else begin
                  st_nxt.seq_state = LCR_SEQ_DONE; // see RULE7
               end
            end
         end
         LCR_SEQ_DONE: begin
            // A single pattern stays finished until the run bit is cleared
            if (!seq_reg[LCR_SEQ_RUN_BIT]) begin
               st_nxt.seq_state = LCR_SEQ_IDLE; // see RULE7
            end
         end
         default: begin
            st_nxt.seq_state = LCR_SEQ_IDLE;
         end
      endcase

      // Current limits
      st_nxt.rgb1 = lcr_split_limits(st_r.regs[LCR_IX_RGB1]); // see RULE9
      st_nxt.rgb2 = lcr_split_limits(st_r.regs[LCR_IX_RGB2]); // see RULE10

      // Audio follow and converter input
      st_nxt.audio.gain_code  = aud_reg[LCR_AUD_GAIN_LSB +: 3]; // see RULE11
      st_nxt.audio.gain_db    = 5'({2'h0, aud_reg[LCR_AUD_GAIN_LSB +: 3]}
                                   * LCR_GAIN_STEP_DB); // see RULE11
      st_nxt.audio.freq_mode  = aud_reg[LCR_AUD_MODE_BIT]; // see RULE12
      st_nxt.audio.auto_level = aud_reg[LCR_AUD_AGC_BIT]; // see RULE13
      st_nxt.audio.follow     = aud_reg[LCR_AUD_FOLLOW_BIT]; // see RULE15
      st_nxt.audio.source     = aud_reg[LCR_AUD_SRC_LSB +: 2]; // see RULE14
   end

   // Decoded outputs lag the registers by one cycle and are flops; seq_o loop and curve come straight from the register bits
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r                  <= '0;
         st_r.regs             <= LCR_RESET;
         st_r.rate             <= LCR_RATE_2M00;
         st_r.seq_state        <= LCR_SEQ_IDLE;
         st_r.audio.source     <= LCR_RESET[LCR_IX_AUD][LCR_AUD_SRC_LSB +: 2];
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_o   = st_r.rdata;
   assign boost_rate_o  = st_r.rate;
   assign flash_o       = st_r.flash;
   // One driver for the whole struct keeps the port single-sourced
   assign seq_o         = '{run:     (st_r.seq_state == LCR_SEQ_RUN),
                            restart: st_r.restart,
                            loop:    seq_reg[LCR_SEQ_LOOP_BIT], // see RULE7
                            curve:   seq_reg[LCR_SEQ_CURVE_BIT]}; // see RULE8
   assign rgb1_limits_o = st_r.rgb1;
   assign rgb2_limits_o = st_r.rgb2;
   assign audio_o       = st_r.audio;

endmodule : lcr_regs

/* bench/lcr_regs_sva.sv */
// Port assertions for the lighting control register bank
`timescale 1ns/100ps
module lcr_regs_sva
   import lcr_pkg::*;
#(
   parameter int unsigned FL_STEP_CYC = 20
) (
   // Clock and reset
   input  wire logic            mclk_i,
   input  wire logic            rst_i,
   // Register port
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   input  wire logic [7:0]      reg_addr_i,
   input  wire logic [7:0]      reg_wdata_i,
   input  wire logic [7:0]      reg_rdata_o,
   // Decoded outputs, flash trigger and pattern end inputs
   input  wire logic [1:0]      boost_rate_o,
   input  wire logic            flash_trigger_i,
   input  wire lcr_flash_s      flash_o,
   input  wire logic            seq_pattern_end_i,
   input  wire lcr_seq_s        seq_o,
   input  wire lcr_rgb_limits_s rgb1_limits_o,
   input  wire lcr_rgb_limits_s rgb2_limits_o,
   input  wire lcr_audio_s      audio_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   sequence wr_s(logic [7:0] a);
      reg_wr_i && reg_addr_i == a;
   endsequence
   // A start shows as one restart cycle while running
   sequence start_s;
      seq_o.run && seq_o.restart ##1 !seq_o.restart;
   endsequence

   rate_decode_a: assert property (
      wr_s(8'h0E) |-> ##2 boost_rate_o == ($past(reg_wdata_i[2], 2) ? 2'h2 :
                                           $past(reg_wdata_i[1], 2) ? 2'h1 : 2'h0))
      else $error("boost rate decode wrong");
   flash_fields_a: assert property (
      wr_s(8'h10) |-> ##2 flash_o.dimming == $past(reg_wdata_i[5], 2)
                          && flash_o.level == $past(reg_wdata_i[2:1], 2))
      else $error("flash dimming or level wrong");
   flash_off_a: assert property (
      wr_s(8'h10) and !reg_wdata_i[0] |-> ##2 !flash_o.on)
      else $error("flash on while disabled");
   seq_copy_a: assert property (
      wr_s(8'h11) |=> seq_o.loop == $past(reg_wdata_i[1]) && seq_o.curve == $past(reg_wdata_i[0]))
      else $error("loop or curve copy wrong");
   seq_stop_a: assert property (
      wr_s(8'h11) and !reg_wdata_i[2] |-> ##2 !seq_o.run && !seq_o.restart)
      else $error("sequencer still running");
   seq_start_a: assert property (
      $rose(seq_o.run) |-> start_s)
      else $error("start without single restart");
   rgb_first_a: assert property (
      wr_s(8'h12) |-> ##2 rgb1_limits_o == $past(reg_wdata_i[5:0], 2))
      else $error("group one limits wrong");
   rgb_second_a: assert property (
      wr_s(8'h13) |-> ##2 rgb2_limits_o == $past(reg_wdata_i[5:0], 2))
      else $error("group two limits wrong");
   audio_fields_a: assert property (
      wr_s(8'h2A) |-> ##2 audio_o.gain_code == $past(reg_wdata_i[7:5], 2)
         && audio_o.gain_db == 5'($past(reg_wdata_i[7:5], 2)) * 5'h03
         && {audio_o.freq_mode, audio_o.auto_level, audio_o.follow, audio_o.source}
            == $past(reg_wdata_i[4:0], 2))
      else $error("audio fields wrong");
   unmapped_rd_a: assert property (
      reg_rd_i && !(reg_addr_i inside {8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h2A})
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule : lcr_regs_sva

bind lcr_regs lcr_regs_sva #(.FL_STEP_CYC(FL_STEP_CYC)) u_sva (
   .mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .boost_rate_o(boost_rate_o), .flash_trigger_i(flash_trigger_i), .flash_o(flash_o),
   .seq_pattern_end_i(seq_pattern_end_i), .seq_o(seq_o), .rgb1_limits_o(rgb1_limits_o),
   .rgb2_limits_o(rgb2_limits_o), .audio_o(audio_o));

/* bench/lcr_host_model.sv */
// Host model driving the register strobe port
`timescale 1ns/100ps
module lcr_host_model (
   // Clock
   input  wire logic       mclk_i,
   // Register port
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      @(posedge mclk_i);
      reg_wr_o    <= 1'b0;
      // Released data is inverted so a stale byte never looks valid
      reg_wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      reg_rd_o   <= 1'b1;
      reg_addr_o <= a;
      @(posedge mclk_i);
      reg_rd_o   <= 1'b0;
      @(posedge mclk_i);
      d = reg_rdata_i;
   endtask : rd
endmodule : lcr_host_model

/* bench/lcr_regs_bench.sv */
// Self-checking testbench of the lighting control register bank
`timescale 1ns/100ps
module lcr_regs_bench;
   import lcr_pkg::*;
   localparam int unsigned STEP = 20;
   logic            mclk_i, rst_i, reg_wr, reg_rd, trig, pend;
   logic [7:0]      addr, wdata, rdata, rv;
   logic [1:0]      rate;
   lcr_flash_s      fl;
   lcr_seq_s        sq;
   lcr_rgb_limits_s rgb1, rgb2;
   lcr_audio_s      aud;
   int              errors = 0, tests_run = 0, cyc = 0, n;
   int              fcode[5] = '{8'h01, 8'h09, 8'h11, 8'h19, 8'h18};
   int              flen[5]  = '{STEP, 2 * STEP, 3 * STEP, 4, 0};

   lcr_host_model host (.mclk_i(mclk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
   lcr_regs #(.FL_STEP_CYC(STEP)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .boost_rate_o(rate), .flash_trigger_i(trig), .flash_o(fl), .seq_pattern_end_i(pend),
      .seq_o(sq), .rgb1_limits_o(rgb1), .rgb2_limits_o(rgb2), .audio_o(aud));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : put

   // Counts flash-on cycles after a short trigger; trigger held 4 cycles
   task automatic flash_run(output int k);
      k = 0;
      @(posedge mclk_i);
      trig <= 1'b1;
      for (int i = 0; i < 130; i++) begin
         @(posedge mclk_i);
         if (i == 3) trig <= 1'b0;
         #1;
         if (fl.on === 1'b1) k++;
      end
   endtask : flash_run

   task automatic end_pulse(output int k);
      k = 0;
      @(posedge mclk_i);
      pend <= 1'b1;
      repeat (4) begin
         @(posedge mclk_i);
         pend <= 1'b0;
         #1;
         if (sq.restart === 1'b1) k++;
      end
   endtask : end_pulse

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      rst_i = 1'b1;
      trig  = 1'b0;
      pend  = 1'b0;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
      chk(16'(rate), 16'h0002);
      chk(16'(aud), 16'h0003);
      for (int i = 0; i < LCR_NREG; i++) begin
         host.rd(LCR_ADDR[i], rv);
         chk(16'(rv), 16'(LCR_RESET[i]));
         host.wr(LCR_ADDR[i], 8'hFF);
         host.rd(LCR_ADDR[i], rv);
         chk(16'(rv), 16'(LCR_WMASK[i]));
      end
      host.wr(8'h0F, 8'hFF);
      host.rd(8'h0F, rv);
      chk(16'(rv), 16'h0000);
      $display("register map test done");
      for (int v = 0; v < 8; v++) begin
         put(LCR_SWITCHER_RATE_CTRL_ADDR, 8'(v));
         chk(16'(rate), v[2] ? 16'h0002 : v[1] ? 16'h0001 : 16'h0000);
      end
      for (int v = 0; v < 4; v++) begin
         put(LCR_FLASH_DRIVER_CTRL_ADDR, {2'b00, v[0], 2'b00, v[1:0], 1'b0});
         chk(16'(fl), {12'h000, 1'b0, v[0], v[1:0]});
      end
      for (int i = 0; i < 5; i++) begin
         put(LCR_FLASH_DRIVER_CTRL_ADDR, 8'(fcode[i]));
         flash_run(n);
         chk(16'(n), 16'(flen[i]));
      end
      $display("flash test done");
      // Map test left the sequencer running; stop it so the start is seen
      put(LCR_PATTERN_SEQUENCER_CTRL_ADDR, 8'h00);
      host.wr(LCR_PATTERN_SEQUENCER_CTRL_ADDR, 8'h06);
      @(posedge mclk_i);
      #1;
      chk(16'(sq), 16'h000E);
      @(posedge mclk_i);
      #1;
      chk(16'(sq), 16'h000A);
      end_pulse(n);
      chk(16'(n), 16'h0001);
      put(LCR_PATTERN_SEQUENCER_CTRL_ADDR, 8'h04);
      chk(16'(sq), 16'h0008);
      end_pulse(n);
      chk(16'(n + 16 * sq.run), 16'h0000);
      put(LCR_PATTERN_SEQUENCER_CTRL_ADDR, 8'h00);
      put(LCR_PATTERN_SEQUENCER_CTRL_ADDR, 8'h05);
      chk(16'(sq), 16'h0009);
      put(LCR_PATTERN_SEQUENCER_CTRL_ADDR, 8'h00);
      chk(16'(sq), 16'h0000);
      $display("sequencer test done");
      put(LCR_RGB_GROUP1_LIMITS_ADDR, 8'hE4);
      chk(16'(rgb1), 16'h0024);
      put(LCR_RGB_GROUP2_LIMITS_ADDR, 8'h1B);
      chk(16'(rgb2), 16'h001B);
      for (int g = 0; g < 8; g++) begin
         put(LCR_AUDIO_FOLLOW_CTRL1_ADDR, {g[2:0], 5'h16 ^ 5'(g)});
         chk(16'(aud), {3'h0, g[2:0], 5'(g * 3), 5'h16 ^ 5'(g)});
      end
      $display("limits and audio test done");
      report_and_stop();
   end
endmodule : lcr_regs_bench
